// file: pcsm_reg_bank.v
// paged register bank with sticky notifies and subsystem state readback
`timescale 1ns/1ps
`default_nettype none
`include "pcsm_regs.vh"

module pcsm_reg_bank (
    input  wire       clk_sys,      // system clock, 250 MHz
    input  wire       rst,          // async reset, active high
    input  wire       nvmProgrammed,// nvm holds a profile
    input  wire       wrStb,        // one-cycle register write strobe
    input  wire       rdStb,        // one-cycle register read strobe
    input  wire [7:0] regAddr,      // register offset within page
    input  wire [7:0] wrData,       // write data
    output reg  [7:0] rdData,       // read data, valid cycle after rdStb
    output reg        rdValid,      // read data valid pulse
    input  wire [3:0] inputLoss,    // live input absent per input
    input  wire [7:0] driftLive,    // live coarse[7:4] / fine[3:0] drift
    input  wire       refLoss,      // live internal reference loss
    input  wire [3:0] pllUnlocked,  // live lock loss per PLL
    input  wire [3:0] pllHoldover,  // live holdover per PLL
    input  wire [3:0] pllFreeRun,   // PLL outer loop disabled
    input  wire       cfgDone,      // host marks programming complete
    output wire [6:0] subsysPowered // power of input..PLL D subsystems
);

    // one-hot main states
    localparam [2:0] S_IDLE = 3'b001;
    localparam [2:0] S_PRG  = 3'b010;
    localparam [2:0] S_ACT  = 3'b100;

    reg  [7:0] page;
    reg  [2:0] mainState;
    reg  [7:0] stateSel [0:7];
    reg  [7:0] pllMask  [0:3];
    reg  [7:0] dbgSel   [0:3];
    reg  [7:0] lossMask;
    reg  [7:0] driftMask;
    reg  [7:0] stickyPll;   // lock loss [3:0], holdover [7:4]
    reg  [3:0] stickyLoss;
    reg        stickyRef;
    reg  [7:0] driftSticky;
    reg  [6:0] pwrForce;
    reg  [6:0] pwrEn;
    reg  [7:0] next_rdData;
    reg  [7:0] stView;
    reg  [2:0] slot;
    integer    i;
    integer    j;           // loop index of the combinational mask gate

    wire isMaster = (page == `PCSM_PG_MASTER);
    wire isClkmon = (page == `PCSM_PG_CLKMON);
    wire isPll    = (page >= `PCSM_PG_PLLA) && (page <= `PCSM_PG_PLLD);
    wire [1:0] pllIdx = page[1:0] - 2'h2;
    wire wrHit = wrStb;

    // subsystems wake only from master page programming of pwrForce and pwrEn
    assign subsysPowered = pwrForce & pwrEn;

    // slot of the page for per-page selector storage
    always @* begin
        slot = 3'h0;
        if (isPll)
            slot = {1'b1, pllIdx};
        else if (page <= `PCSM_PG_OUTPUT)
            slot = page[2:0];
    end

    // master state machine: idle for one cycle, then program-wait until nvm or host programming
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            mainState <= S_IDLE;
        end else begin
            case (mainState)
                S_IDLE: begin
                    mainState <= S_PRG;
                end
                S_PRG: begin
                    if (nvmProgrammed || cfgDone)
                        mainState <= S_ACT;
                end
                S_ACT: begin
                    mainState <= S_ACT;
                end
                default: begin
                    mainState <= S_IDLE;
                end
            endcase
        end
    end

    // subsystem state follows master once nvm is programmed or any pwrEn bit is set
    function [7:0] pick;
        input [2:0] st;
        input [7:0] prg;
        input [7:0] act;
        begin
            case (st)
                S_PRG:   pick = prg;
                S_ACT:   pick = act;
                default: pick = `PCSM_ST_IDLE;
            endcase
        end
    endfunction

    wire [2:0] slaveSt = (nvmProgrammed || pwrEn != 7'h00) ?
                         mainState : S_IDLE;

    // state view: valid only for the documented selector value
    always @* begin
        stView = `PCSM_ST_IDLE;
        case (page)
            `PCSM_PG_MASTER: if (stateSel[0] == `PCSM_SEL_MASTER)
                stView = pick(mainState, `PCSM_ST_M_PRG,
                              `PCSM_ST_M_ACT);
            `PCSM_PG_CLKMON: if (stateSel[1] == `PCSM_SEL_MASTER)
                stView = pick(slaveSt, `PCSM_ST_C_PRG,
                              `PCSM_ST_C_ACT);
            `PCSM_PG_INPUT: if (stateSel[2] == `PCSM_SEL_MASTER)
                stView = pick(slaveSt, `PCSM_ST_I_PRG,
                              `PCSM_ST_I_ACT);
            `PCSM_PG_OUTPUT: if (stateSel[3] == `PCSM_SEL_OUTPUT)
                stView = pick(slaveSt, `PCSM_ST_O_PRG,
                              `PCSM_ST_O_ACT);
            default: if (isPll && stateSel[slot] == `PCSM_SEL_PLL)
                stView = pick(slaveSt, `PCSM_ST_P_PRG,
                              `PCSM_ST_P_ACT);
        endcase
    end

    // read mux; unmapped offsets read zero
    always @* begin
        next_rdData = `PCSM_RST_ZERO;
        case (regAddr)
            `PCSM_A_PAGE:     next_rdData = page;
            `PCSM_A_STATESEL: next_rdData = stateSel[slot];
            `PCSM_A_STATE:    next_rdData = stView;
            default: begin
                if (isMaster) begin
                    if (regAddr == `PCSM_A_STICKY)
                        next_rdData = stickyPll;
                    if (regAddr == `PCSM_A_LOSS)
                        next_rdData = {5'h00, stickyRef, 2'h0};
                    if (regAddr == `PCSM_A_PWRFORCE)
                        next_rdData = {1'b0, pwrForce};
                    if (regAddr == `PCSM_A_PWREN)
                        next_rdData = {1'b0, pwrEn};
                end else if (isClkmon) begin
                    if (regAddr == `PCSM_A_LOSS)
                        next_rdData = {4'h0, stickyLoss};
                    if (regAddr == `PCSM_A_STICKY)
                        next_rdData = driftSticky;
                    if (regAddr == `PCSM_A_LOSSMASK)
                        next_rdData = driftMask;
                end else if (isPll) begin
                    if (regAddr == `PCSM_A_LOCKLIVE)
                        next_rdData = {7'h00, pllUnlocked[pllIdx]};
                    if (regAddr == `PCSM_A_MASK)
                        next_rdData = pllMask[pllIdx];
                    if (regAddr == `PCSM_A_OUTERLOOP)
                        next_rdData = {pllFreeRun[pllIdx], 7'h00};
                    if (regAddr == `PCSM_A_DBGSEL)
                        next_rdData = dbgSel[pllIdx];
                    if (regAddr == `PCSM_A_HOVIEW &&
                        dbgSel[pllIdx] == `PCSM_DBG_HOLD)
                        next_rdData = {4'h0, pllHoldover[pllIdx] |
                                       pllFreeRun[pllIdx], 3'h0};
                end
            end
        endcase
    end

    // read data registered one cycle after the strobe
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rdData  <= `PCSM_RST_ZERO;
            rdValid <= 1'b0;
        end else begin
            rdValid <= rdStb;
            if (rdStb)
                rdData <= next_rdData;
        end
    end

    // configuration writes
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            page      <= `PCSM_PG_MASTER;
            lossMask  <= `PCSM_RST_ZERO;
            driftMask <= `PCSM_RST_ZERO;
            pwrForce  <= 7'h00;
            pwrEn     <= 7'h00;
            for (i = 0; i < 8; i = i + 1)
                stateSel[i] <= `PCSM_RST_ZERO;
            for (i = 0; i < 4; i = i + 1) begin
                pllMask[i] <= `PCSM_RST_ZERO;
                dbgSel[i]  <= `PCSM_RST_ZERO;
            end
        end else if (wrHit) begin
            if (regAddr == `PCSM_A_PAGE)
                page <= wrData;
            if (regAddr == `PCSM_A_STATESEL)
                stateSel[slot] <= wrData;
            if (isMaster && regAddr == `PCSM_A_PWRFORCE)
                pwrForce <= wrData[6:0];
            if (isMaster && regAddr == `PCSM_A_PWREN)
                pwrEn <= wrData[6:0];
            if (isMaster && regAddr == `PCSM_A_LOSSMASK)
                lossMask <= wrData;
            if (isClkmon && regAddr == `PCSM_A_LOSSMASK)
                driftMask <= wrData;
            if (isPll && regAddr == `PCSM_A_MASK)
                pllMask[pllIdx] <= wrData;
            if (isPll && regAddr == `PCSM_A_DBGSEL)
                dbgSel[pllIdx] <= wrData;
        end
    end

    // unmask gates of the pll sticky bits
    reg [7:0] pllEnable;
    always @* begin
        pllEnable = 8'h00;
        for (j = 0; j < 4; j = j + 1) begin
            pllEnable[j]   = pllMask[j][0];
            pllEnable[j+4] = pllMask[j][`PCSM_HO_BIT-1];
        end
    end

    wire clrPll   = wrHit && isMaster && regAddr == `PCSM_A_STICKY;
    wire clrRef   = wrHit && isMaster && regAddr == `PCSM_A_LOSS;
    wire clrLoss  = wrHit && isClkmon && regAddr == `PCSM_A_LOSS;
    wire clrDrift = wrHit && isClkmon && regAddr == `PCSM_A_STICKY;
    wire [7:0] pllEv = {pllHoldover, pllUnlocked} & pllEnable;

    // sticky bits: set wins over a same-cycle clear; zero writes keep
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            stickyPll   <= `PCSM_RST_ZERO;
            stickyLoss  <= 4'h0;
            stickyRef   <= 1'b0;
            driftSticky <= `PCSM_RST_ZERO;
        end else begin
            stickyPll <= (stickyPll & ~(clrPll ? wrData : 8'h00))
                         | pllEv;
            stickyLoss <= (stickyLoss & ~(clrLoss ? wrData[3:0] : 4'h0))
                          | (inputLoss & driftMask[3:0]);
            stickyRef <= (stickyRef &
                          ~(clrRef & wrData[`PCSM_XO_BIT]))
                         | (refLoss & lossMask[`PCSM_XO_BIT + 2]);
            driftSticky <= (driftSticky & ~(clrDrift ? wrData : 8'h00))
                           | (driftLive & driftMask);
        end
    end

endmodule // pcsm_reg_bank
`default_nettype wire

// file: pcsm_regs.vh
// register map constants for the paged configuration state monitor
//
// Overview of operation
// - page select write switches page, reads back
// - page codes: 0,1,2,3 and 0x0A-0x0D
// - master page 0x7 write ones clears PLL notifies
// - monitor page 0x3 bits 3:0 clear loss
// - monitor page 0x7 write ones clears drift notifies
// - unprogrammed device never wakes subsystems itself
// - master page programming powers up subsystems
// - master state view reads 9, 0, 36
// - monitor state view low nibble 5, 0, 12
// - input state view low five bits 7, 0, 23
// - output state view low five bits 12, 0, 20
// - PLL state view reads 8, 0, 48
// - PLL page 0x04 bit 0 unmasks lock loss
// - PLL page 0x02 bit 0 shows out of lock
// - PLL page 0x17 bit 7 marks free-run holdover
// - with 0xB3 = 0x0D, 0xB9 bit 3 shows holdover
// - sticky notify sets only when mask bit is one
// - master page 0x3 bit 2 clears reference loss
`ifndef PCSM_REGS_VH
`define PCSM_REGS_VH

`define PCSM_PG_MASTER   8'h00
`define PCSM_PG_CLKMON   8'h01
`define PCSM_PG_INPUT    8'h02
`define PCSM_PG_OUTPUT   8'h03
`define PCSM_PG_PLLA     8'h0a
`define PCSM_PG_PLLD     8'h0d

`define PCSM_A_LOCKLIVE  8'h02
`define PCSM_A_LOSS      8'h03
`define PCSM_A_MASK      8'h04
`define PCSM_A_STICKY    8'h07
`define PCSM_A_LOSSMASK  8'h08
`define PCSM_A_OUTERLOOP 8'h17
`define PCSM_A_DBGSEL    8'hb3
`define PCSM_A_HOVIEW    8'hb9
`define PCSM_A_STATE     8'hd0
`define PCSM_A_STATESEL  8'hd1
`define PCSM_A_PWRFORCE  8'he0
`define PCSM_A_PWREN     8'he1
`define PCSM_A_PAGE      8'hff

`define PCSM_SEL_MASTER  8'h40
`define PCSM_SEL_OUTPUT  8'h60
`define PCSM_SEL_PLL     8'h20
`define PCSM_DBG_HOLD    8'h0d
`define PCSM_HO_BIT      3
`define PCSM_FREERUN_BIT 7
`define PCSM_XO_BIT      2

// state codes: program-wait, idle, active per subsystem
`define PCSM_ST_M_PRG    8'h09
`define PCSM_ST_M_ACT    8'h24
`define PCSM_ST_C_PRG    8'h05
`define PCSM_ST_C_ACT    8'h0c
`define PCSM_ST_I_PRG    8'h07
`define PCSM_ST_I_ACT    8'h17
`define PCSM_ST_O_PRG    8'h0c
`define PCSM_ST_O_ACT    8'h14
`define PCSM_ST_P_PRG    8'h08
`define PCSM_ST_P_ACT    8'h30
`define PCSM_ST_IDLE     8'h00

`define PCSM_RST_ZERO    8'h00

`endif

// file: pcsm_monitor.sv
// assertion checker for the paged register bank
`timescale 1ns/1ps
`default_nettype none
`include "pcsm_regs.vh"
module pcsm_monitor (
    input wire logic       clk_sys,       // clock
    input wire logic       rst,           // reset
    input wire logic       nvmProgrammed, // nvm loaded
    input wire logic       wrStb,         // write
    input wire logic       rdStb,         // read
    input wire logic [7:0] regAddr,       // offset
    input wire logic [7:0] wrData,        // wdata
    input wire logic [7:0] rdData,        // rdata
    input wire logic       rdValid,       // rvalid
    input wire logic [3:0] inputLoss,     // loss
    input wire logic [7:0] driftLive,     // drift
    input wire logic       refLoss,       // ref loss
    input wire logic [3:0] pllUnlocked,   // unlock
    input wire logic [3:0] pllHoldover,   // holdover
    input wire logic [3:0] pllFreeRun,    // free run
    input wire logic       cfgDone,       // done
    input wire logic [6:0] subsysPowered  // power
);
    logic [7:0] pg;
    wire isPll = pg >= 8'h0a && pg <= 8'h0d;
    wire unlk = pllUnlocked[pg[1:0] - 2'd2];
    // shadow page, updated on the same edge as the bank's own copy
    always_ff @(posedge clk_sys or posedge rst)
        if (rst) pg <= 8'h00;
        else if (wrStb && regAddr == `PCSM_A_PAGE) pg <= wrData;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    sequence pageWr; wrStb && regAddr == `PCSM_A_PAGE; endsequence
    sequence pageRd; rdStb && !wrStb && regAddr == `PCSM_A_PAGE; endsequence
    sequence stRd; rdStb && regAddr == `PCSM_A_STATE; endsequence
    AST_RD_ANSWER: assert property (rdStb |=> rdValid)
        else $error("read not answered");
    AST_RD_HOLD: assert property (!rdStb |=> $stable(rdData))
        else $error("read data moved");
    AST_PAGE_ECHO: assert property (pageWr ##1 !wrStb ##1 pageRd
        |=> rdData == $past(wrData, 3)) else $error("page echo");
    AST_NO_WAKE: assert property ($changed(subsysPowered)
        |-> $past(wrStb)) else $error("power changed alone");
    AST_MAIN_CODES: assert property (stRd and pg == 8'h00
        |=> rdData inside {8'h00, 8'h09, 8'h24}) else $error("main code");
    AST_OUT_CODES: assert property (stRd and pg == 8'h03
        |=> rdData[4:0] inside {5'h00, 5'h0c, 5'h14}) else $error("out code");
    AST_PLL_CODES: assert property (stRd and isPll
        |=> rdData inside {8'h00, 8'h08, 8'h30}) else $error("pll code");
    AST_LOCK_LIVE: assert property (rdStb && regAddr == 8'h02 && isPll
        |=> rdData[0] == $past(unlk)) else $error("lock status");
endmodule // pcsm_monitor
bind pcsm_reg_bank pcsm_monitor mon (.clk_sys(clk_sys), .rst(rst),
    .nvmProgrammed(nvmProgrammed), .wrStb(wrStb), .rdStb(rdStb),
    .regAddr(regAddr), .wrData(wrData), .rdData(rdData), .rdValid(rdValid),
    .inputLoss(inputLoss), .driftLive(driftLive), .refLoss(refLoss),
    .pllUnlocked(pllUnlocked), .pllHoldover(pllHoldover),
    .pllFreeRun(pllFreeRun), .cfgDone(cfgDone), .subsysPowered(subsysPowered));
`default_nettype wire

// file: pcsm_host_model.sv
// host model issuing register writes and reads
`timescale 1ns/1ps
`default_nettype none
module pcsm_host_model (
    input  wire logic       clk_sys, // clock
    output var  logic       wrStb,   // write
    output var  logic       rdStb,   // read
    output var  logic [7:0] regAddr, // offset
    output var  logic [7:0] wrData,  // wdata
    input  wire logic [7:0] rdData,  // rdata
    input  wire logic       rdValid  // rvalid
);
    logic tmo;
    initial {wrStb, rdStb, regAddr, wrData, tmo} = 19'h00000;
    // entered at a falling edge; released lines show the inverse, not stale
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        wrStb = 1'b1;
        regAddr = a;
        wrData = d;
        @(posedge clk_sys);
        // release on the falling edge, then idle a cycle before the next call
        @(negedge clk_sys);
        wrStb = 1'b0;
        regAddr = ~a;
        wrData = ~d;
        @(negedge clk_sys);
    endtask
    // answer is awaited for a few edges only, so a dead bank cannot hang us
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        int i;
        rdStb = 1'b1;
        regAddr = a;
        tmo = 1'b1;
        d = 8'h00;
        @(posedge clk_sys);
        @(negedge clk_sys);
        rdStb = 1'b0;
        regAddr = ~a;
        // rdValid stands for one cycle only, so look at every falling edge
        for (i = 0; i < 4 && tmo; i++) begin
            if (rdValid === 1'b1) begin
                d = rdData;
                tmo = 1'b0;
            end else begin
                @(negedge clk_sys);
            end
        end
        @(negedge clk_sys);
    endtask
endmodule // pcsm_host_model
`default_nettype wire

// file: pcsm_reg_bank_tb_top.sv
// self-checking bench for the paged register bank
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin nChecks++; if ((g) !== (e)) begin mismatches++; \
    $display("BAD %0t got %h want %h", $time, g, e); end end
module pcsm_reg_bank_tb_top;
    logic clk_sys, rst, nvmProgrammed, wrStb, rdStb, rdValid, refLoss, cfgDone;
    logic [7:0] regAddr, wrData, rdData, driftLive;
    logic [3:0] inputLoss, pllUnlocked, pllHoldover, pllFreeRun;
    logic [6:0] subsysPowered;
    int mismatches = 0;
    int nChecks = 0;
    // page, selector, mask, program-wait code, active code
    logic [39:0] tab [7] = '{40'h02401f0717, 40'h01400f050c, 40'h03601f0c14,
        40'h0a20ff0830, 40'h0b20ff0830, 40'h0c20ff0830, 40'h0d20ff0830};
    pcsm_reg_bank dut (.clk_sys(clk_sys), .rst(rst),
        .nvmProgrammed(nvmProgrammed), .wrStb(wrStb), .rdStb(rdStb),
        .regAddr(regAddr), .wrData(wrData), .rdData(rdData),
        .rdValid(rdValid), .inputLoss(inputLoss), .driftLive(driftLive),
        .refLoss(refLoss), .pllUnlocked(pllUnlocked),
        .pllHoldover(pllHoldover), .pllFreeRun(pllFreeRun),
        .cfgDone(cfgDone), .subsysPowered(subsysPowered));
    pcsm_host_model host (.clk_sys(clk_sys), .wrStb(wrStb), .rdStb(rdStb),
        .regAddr(regAddr), .wrData(wrData), .rdData(rdData),
        .rdValid(rdValid));
    always #2 clk_sys = ~clk_sys;
    task automatic wrap_up();
        if (mismatches == 0 && nChecks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic chkRd(input logic [7:0] a, m, e);
        logic [7:0] d;
        host.rd(a, d);
        if (host.tmo) begin
            mismatches++;
            wrap_up();
        end
        `CHK(d & m, e)
    endtask
    // a one-cycle event on the live inputs, then back to quiet
    task automatic pulse(input logic [3:0] il, pu, ph, input logic rl);
        {inputLoss, driftLive, refLoss, pllUnlocked, pllHoldover} =
            {il, {il, il}, rl, pu, ph};
        @(negedge clk_sys);
        {inputLoss, driftLive, refLoss, pllUnlocked, pllHoldover} = 21'h0;
    endtask
    task automatic t_page();
        foreach (tab[i]) begin
            host.wr(8'hff, tab[i][39:32]);
            chkRd(8'hff, 8'hff, tab[i][39:32]);
        end
    endtask
    // inputs engaged and every PLL in use, so all slave pages are set up
    task automatic t_slaves(input logic act);
        foreach (tab[i]) begin
            host.wr(8'hff, tab[i][39:32]);
            host.wr(8'hd1, tab[i][31:24]);
            chkRd(8'hd0, tab[i][23:16], act ? tab[i][7:0] : tab[i][15:8]);
        end
    endtask
    task automatic t_state();
        chkRd(8'hff, 8'hff, 8'h00);
        host.wr(8'hd1, 8'h40);
        chkRd(8'hd0, 8'hff, 8'h09);
        host.wr(8'hff, 8'h02);
        host.wr(8'hd1, 8'h40);
        chkRd(8'hd0, 8'h1f, 8'h00);
        host.wr(8'hff, 8'h00);
        host.wr(8'he0, 8'h7f);
        host.wr(8'he1, 8'h7f);
        `CHK(subsysPowered, 7'h7f)
        host.wr(8'hd1, 8'h41);
        chkRd(8'hd0, 8'hff, 8'h00);
        t_slaves(1'b0);
        cfgDone = 1'b1;
        t_slaves(1'b1);
        host.wr(8'hff, 8'h00);
        host.wr(8'hd1, 8'h40);
        chkRd(8'hd0, 8'hff, 8'h24);
        cfgDone = 1'b0;
    endtask
    task automatic t_sticky();
        host.wr(8'hff, 8'h01);
        pulse(4'hf, 4'h0, 4'h0, 1'b0);
        chkRd(8'h03, 8'h0f, 8'h00);
        host.wr(8'h08, 8'hff);
        pulse(4'hf, 4'h0, 4'h0, 1'b0);
        host.wr(8'h03, 8'h00);
        chkRd(8'h03, 8'h0f, 8'h0f);
        host.wr(8'h03, 8'h0f);
        chkRd(8'h03, 8'h0f, 8'h00);
        chkRd(8'h07, 8'hff, 8'hff);
        host.wr(8'h07, 8'hff);
        chkRd(8'h07, 8'hff, 8'h00);
        host.wr(8'hff, 8'h00);
        host.wr(8'h08, 8'h10);
        pulse(4'h0, 4'h0, 4'h0, 1'b1);
        chkRd(8'h03, 8'h04, 8'h04);
        host.wr(8'h03, 8'h04);
        chkRd(8'h03, 8'h04, 8'h00);
        host.wr(8'hff, 8'h0a);
        host.wr(8'h04, 8'h05);
        pulse(4'h0, 4'h1, 4'h1, 1'b0);
        host.wr(8'hff, 8'h00);
        chkRd(8'h07, 8'hff, 8'h11);
        host.wr(8'h07, 8'hff);
        chkRd(8'h07, 8'hff, 8'h00);
    endtask
    task automatic t_pll();
        host.wr(8'hff, 8'h0b);
        pllUnlocked = 4'h2;
        chkRd(8'h02, 8'h01, 8'h01);
        pllUnlocked = 4'h0;
        chkRd(8'h02, 8'h01, 8'h00);
        pllFreeRun = 4'h2;
        chkRd(8'h17, 8'h80, 8'h80);
        host.wr(8'hb3, 8'h0d);
        chkRd(8'hb9, 8'h08, 8'h08);
        pllFreeRun = 4'h0;
        chkRd(8'hb9, 8'h08, 8'h00);
        pllHoldover = 4'h2;
        chkRd(8'hb9, 8'h08, 8'h08);
    endtask
    initial begin
        {clk_sys, nvmProgrammed, refLoss, cfgDone, driftLive} = 12'h0;
        {inputLoss, pllUnlocked, pllHoldover, pllFreeRun} = 16'h0;
        rst = 1'b1;
        repeat (3) @(posedge clk_sys);
        @(negedge clk_sys);
        rst = 1'b0;
        repeat (2) @(negedge clk_sys);
        t_state();
        t_page();
        t_sticky();
        t_pll();
        wrap_up();
    end
endmodule // pcsm_reg_bank_tb_top
`default_nettype wire
